/* File: rtl/rail_ctrl_regs.sv */
// Rail enable, forced shutdown, voltage code and phase registers.
// Assumes a serial bus engine on sys_clk drives the register port; the
// enable pin is asynchronous and is synchronised here.

// Behaviour
// - Setting the force-off bit while enable pin is high starts shutdown.
// - Force-off bit clears when enable pin is low; resets to zero.
// - Rail1 code is 8-bit RW, base 2.1 V, 20 mV step, reset 0x3c.
// - Rail2 code is 8-bit RW, base 1.5 V, 20 mV step, reset 0x0f.
// - Rail3 code is 8-bit RW, base 0.9 V, 5 mV step, reset 0x3c.
// - Rail4 code is 8-bit RW, base 0.8 V, 5 mV step, reset 0x28.
// - Every voltage code stores and reads back any value unclamped.
// - Two-bit phase codes 0..3 mean 0, 90, 180, 270 degrees.
// - Phase fields read-only: 3,2,1,0 for rails four down to one.
module rail_ctrl_regs
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register port
   input wire rail_ctrl_pkg::reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // External enable pin
   input wire logic enable_pin,
   // Rail controls
   output logic [4:0] rail_on,
   output logic [3:0][7:0] rail_vcode,
   output logic [7:0] rail_phase,
   output logic shutdown_req,
   output logic shutdown_start
);
   import rail_ctrl_pkg::*;

   ctrl_state_s state_ff;
   ctrl_state_s nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.pin_meta = enable_pin;
      nxt_state.pin_sync = state_ff.pin_meta;
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            OFS_RAIL_ENABLE:
            begin
               nxt_state.rail_on = reg_req.wdata[POS_RAIL4_ON:POS_LINEAR_ON];
               nxt_state.force_off = reg_req.wdata[POS_FORCE_OFF];
            end
            OFS_RAIL1_VCODE: nxt_state.vcode[0] = reg_req.wdata;
            OFS_RAIL2_VCODE: nxt_state.vcode[1] = reg_req.wdata;
            OFS_RAIL3_VCODE: nxt_state.vcode[2] = reg_req.wdata;
            OFS_RAIL4_VCODE: nxt_state.vcode[3] = reg_req.wdata;
            default: nxt_state.rail_on = state_ff.rail_on;
         endcase
      end
      if (!state_ff.pin_sync)
      begin
         nxt_state.force_off = 1'b0;
      end
      // Read data holds until the next read
      nxt_state.rdata = state_ff.rdata;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            OFS_RAIL_ENABLE: nxt_state.rdata =
               {2'h0, state_ff.force_off, state_ff.rail_on};
            OFS_RAIL1_VCODE: nxt_state.rdata = state_ff.vcode[0];
            OFS_RAIL2_VCODE: nxt_state.rdata = state_ff.vcode[1];
            OFS_RAIL3_VCODE: nxt_state.rdata = state_ff.vcode[2];
            OFS_RAIL4_VCODE: nxt_state.rdata = state_ff.vcode[3];
            OFS_RAIL_PHASE: nxt_state.rdata = PHASE_WORD;
            default: nxt_state.rdata = 8'h00;
         endcase
      end
      // request delayed, reads only the second sync flop
      nxt_state.shut_start = state_ff.force_off && state_ff.pin_sync;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_ff.pin_meta <= 1'b0;
         state_ff.pin_sync <= 1'b0;
         state_ff.force_off <= RST_FORCE_OFF;
         state_ff.rail_on <= RST_RAIL_ON;
         state_ff.vcode <= RST_VCODES;
         state_ff.rdata <= 8'h00;
         state_ff.shut_start <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata = state_ff.rdata;
   assign rail_on = state_ff.rail_on;
   assign rail_vcode = state_ff.vcode;
   assign rail_phase = PHASE_WORD;
   assign shutdown_req = state_ff.force_off && state_ff.pin_sync;
   // start pulse, first cycle of a request
   assign shutdown_start = shutdown_req && !state_ff.shut_start;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence seq_force_write;
      reg_req.wr && reg_req.addr == OFS_RAIL_ENABLE
         && reg_req.wdata[POS_FORCE_OFF];
   endsequence

   sequence seq_pin_high;
      state_ff.pin_sync;
   endsequence

   a_force_set_start: assert property (
      (seq_force_write and seq_pin_high) ##1 state_ff.pin_sync
      |-> shutdown_req)
      else $error("force-off write with pin high did not request shutdown");

   a_start_on_rise: assert property (
      $rose(shutdown_req) |-> shutdown_start ##1 !shutdown_start)
      else $error("shutdown start pulse missing or too long");

   a_pin_low_clear: assert property (
      !state_ff.pin_sync |=> !state_ff.force_off)
      else $error("force-off bit not cleared while pin low");

   a_reset_values: assert property (
      $past(reset) |-> rail_on == RST_RAIL_ON && rail_vcode == RST_VCODES
         && !state_ff.force_off)
      else $error("wrong reset value");

   a_rail1_store: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL1_VCODE
      |=> rail_vcode[0] == $past(reg_req.wdata))
      else $error("rail1 code not stored");

   a_rail4_store: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL4_VCODE
      |=> rail_vcode[3] == $past(reg_req.wdata))
      else $error("rail4 code not stored");

   a_rail2_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL2_VCODE
      |=> reg_rdata == $past(rail_vcode[1]))
      else $error("rail2 code read back wrong");

   a_phase_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL_PHASE |=> reg_rdata == 8'he4)
      else $error("phase word read wrong");

   a_enable_write: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL_ENABLE
      |=> rail_on == $past(reg_req.wdata[4:0]))
      else $error("on bits not written");

   // Read-back and store of the remaining registers
   a_rail1_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL1_VCODE
      |=> reg_rdata == $past(rail_vcode[0]))
      else $error("rail1 code read back wrong");

   a_rail3_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL3_VCODE
      |=> reg_rdata == $past(rail_vcode[2]))
      else $error("rail3 code read back wrong");

   a_rail4_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL4_VCODE
      |=> reg_rdata == $past(rail_vcode[3]))
      else $error("rail4 code read back wrong");

   a_enable_read: assert property (
      reg_req.rd && reg_req.addr == OFS_RAIL_ENABLE
      |=> reg_rdata == {2'h0, $past(state_ff.force_off), $past(rail_on)})
      else $error("enable register read back wrong");

   a_rail2_store: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL2_VCODE
      |=> rail_vcode[1] == $past(reg_req.wdata))
      else $error("rail2 code not stored");

   a_rail3_store: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL3_VCODE
      |=> rail_vcode[2] == $past(reg_req.wdata))
      else $error("rail3 code not stored");

   a_ro_write_ignored: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL_PHASE
      |=> $stable(rail_vcode) && $stable(rail_on))
      else $error("write to phase offsets changed a register");

   // Force-off bit and start pulse
   a_force_write: assert property (
      reg_req.wr && reg_req.addr == OFS_RAIL_ENABLE && state_ff.pin_sync
      |=> state_ff.force_off == $past(reg_req.wdata[POS_FORCE_OFF]))
      else $error("force-off bit not written while pin high");

   a_force_hold: assert property (
      state_ff.force_off && state_ff.pin_sync
      && !(reg_req.wr && reg_req.addr == OFS_RAIL_ENABLE)
      |=> state_ff.force_off)
      else $error("force-off bit lost while pin high");

   a_start_one_shot: assert property (
      shutdown_start |=> !shutdown_start)
      else $error("shutdown start pulse longer than one cycle");

   a_reset_no_start: assert property (
      $past(reset) |-> !shutdown_req && !shutdown_start)
      else $error("shutdown active after reset");

endmodule : rail_ctrl_regs

/* File: rtl/rail_ctrl_pkg.sv */
// Rail control register group: offsets, field layout, reset values.
// Assumes a one-clock device with an internal byte-wide register port.
package rail_ctrl_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RAIL_CNT = 4;
   localparam int ON_CNT = 5;

   // Register offsets
   localparam logic [7:0] OFS_RAIL_ENABLE = 8'h05;
   localparam logic [7:0] OFS_RAIL1_VCODE = 8'h07;
   localparam logic [7:0] OFS_RAIL2_VCODE = 8'h08;
   localparam logic [7:0] OFS_RAIL3_VCODE = 8'h09;
   localparam logic [7:0] OFS_RAIL4_VCODE = 8'h0a;
   localparam logic [7:0] OFS_RAIL_PHASE = 8'h0b;

   // Enable register fields
   localparam int POS_FORCE_OFF = 5;
   localparam int POS_LINEAR_ON = 0;
   localparam int POS_RAIL1_ON = 1;
   localparam int POS_RAIL4_ON = 4;
   localparam logic [4:0] RST_RAIL_ON = 5'h1f;
   localparam logic RST_FORCE_OFF = 1'b0;

   // Voltage code reset values
   localparam logic [7:0] RST_RAIL1_VCODE = 8'h3c;
   localparam logic [7:0] RST_RAIL2_VCODE = 8'h0f;
   localparam logic [7:0] RST_RAIL3_VCODE = 8'h3c;
   localparam logic [7:0] RST_RAIL4_VCODE = 8'h28;
   localparam logic [3:0][7:0] RST_VCODES =
      {RST_RAIL4_VCODE, RST_RAIL3_VCODE, RST_RAIL2_VCODE, RST_RAIL1_VCODE};

   // Fixed phase offsets, 0/90/180/270 degrees as codes 0..3
   localparam logic [1:0] PHASE_RAIL4 = 2'h3;
   localparam logic [1:0] PHASE_RAIL3 = 2'h2;
   localparam logic [1:0] PHASE_RAIL2 = 2'h1;
   localparam logic [1:0] PHASE_RAIL1 = 2'h0;
   localparam logic [7:0] PHASE_WORD =
      {PHASE_RAIL4, PHASE_RAIL3, PHASE_RAIL2, PHASE_RAIL1};

   typedef struct packed {
      logic pin_meta;
      logic pin_sync;
      logic force_off;
      logic [4:0] rail_on;
      logic [3:0][7:0] vcode;
      logic [7:0] rdata;
      logic shut_start;
   } ctrl_state_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage : rail_ctrl_pkg

/* File: sim/reg_host.sv */
// Register host model: single-byte strobes on the register port.
// Assumes a free-running sys_clk and reset already released.
module reg_host
(
   // Clock
   input wire logic sys_clk,
   // Register port
   output rail_ctrl_pkg::reg_req_s reg_req
);
   timeunit 1ns;
   timeprecision 1ns;
   import rail_ctrl_pkg::*;
   initial reg_req = '0;
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(posedge sys_clk);
      reg_req <= '0;
   endtask : xfer
endmodule : reg_host

/* File: sim/tb_top.sv */
// Bench for the rail control registers.
// Assumes reg_host as the only register master.
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
   n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rail_ctrl_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic enable_pin = 1'b1;
   reg_req_s reg_req;
   logic [7:0] reg_rdata;
   logic [4:0] rail_on;
   logic [3:0][7:0] rail_vcode;
   logic [7:0] rail_phase;
   logic shutdown_req;
   logic shutdown_start;
   int n_mismatch = 0;
   int n_tests = 0;
   always #50 sys_clk = ~sys_clk;
   reg_host host (.sys_clk(sys_clk), .reg_req(reg_req));
   rail_ctrl_regs uut (.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .enable_pin(enable_pin), .rail_on(rail_on),
      .rail_vcode(rail_vcode), .rail_phase(rail_phase),
      .shutdown_req(shutdown_req), .shutdown_start(shutdown_start));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
      #1;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00);
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask : rd_chk
   task automatic t_reset();
      logic [7:0] e[6] = '{8'h1f, 8'h3c, 8'h0f, 8'h3c, 8'h28, 8'he4};
      #1;
      `CHK("rail_on", 5'h1f, rail_on)
      `CHK("shutdown_req", 1'b0, shutdown_req)
      for (int i = 0; i < 6; i++)
         rd_chk(8'h05 + 8'(i) + 8'(i > 0), e[i]);
   endtask : t_reset
   task automatic t_codes();
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h07 + 8'(i), 8'hff);
         `CHK("rail_vcode", 8'hff, rail_vcode[i])
         rd_chk(8'h07 + 8'(i), 8'hff);
         wr(8'h07 + 8'(i), 8'h00);
         rd_chk(8'h07 + 8'(i), 8'h00);
      end
   endtask : t_codes
   task automatic t_ro();
      wr(8'h0b, 8'h1b);
      `CHK("rail_phase", 8'he4, rail_phase)
      rd_chk(8'h0b, 8'he4);
      wr(8'h06, 8'hff);
      rd_chk(8'h06, 8'h00);
   endtask : t_ro
   task automatic t_enable();
      wr(8'h05, 8'hca);
      `CHK("rail_on", 5'h0a, rail_on)
      rd_chk(8'h05, 8'h0a);
      wr(8'h05, 8'h15);
      `CHK("rail_on", 5'h15, rail_on)
      wr(8'h05, 8'h1f);
   endtask : t_enable
   task automatic t_shutdown();
      wr(8'h05, 8'h3f);
      `CHK("shutdown_start", 1'b1, shutdown_start)
      `CHK("shutdown_req", 1'b1, shutdown_req)
      @(posedge sys_clk);
      enable_pin <= 1'b0;
      #1;
      `CHK("shutdown_start", 1'b0, shutdown_start)
      repeat (4) @(posedge sys_clk);
      rd_chk(8'h05, 8'h1f);
      wr(8'h05, 8'h3f);
      rd_chk(8'h05, 8'h1f);
      `CHK("shutdown_req", 1'b0, shutdown_req)
   endtask : t_shutdown
   task automatic t_mid_reset();
      wr(8'h07, 8'h55);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      `CHK("rail_vcode", 8'h3c, rail_vcode[0])
      `CHK("shutdown_req", 1'b0, shutdown_req)
      `CHK("rail_on", 5'h1f, rail_on)
      rd_chk(8'h07, 8'h3c);
   endtask : t_mid_reset
   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_codes();
      t_ro();
      t_enable();
      t_shutdown();
      t_mid_reset();
      print_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : tb_top
